// File: hw/fosc_pkg.sv
// Package for the FFT output strobe control block: slots, codes, counts.
// Assumes a 20 MHz system clock and an unrelated output strobe clock.
`default_nettype none

package fosc_pkg;
  // Widths
  localparam int DATA_W = 32;
  localparam int ADDR_W = 10;
  // Twelve-cycle RAM schedule, slot positions
  localparam logic [3:0] SLOT_FIRST = 4'h0;
  localparam logic [3:0] SLOT_LAST = 4'hB;
  localparam logic [3:0] SLOT_IN_A = 4'h0;
  localparam logic [3:0] SLOT_IN_B = 4'h6;
  localparam logic [3:0] SLOT_OUT_A = 4'h5;
  localparam logic [3:0] SLOT_OUT_B = 4'hB;
  localparam logic [3:0] PHASE_ONE = 4'h1;
  // Timing counts in system clock cycles
  localparam int SYS_CLK_MHZ = 20;
  localparam int WORST_LOAD_CYC = 6;
  localparam logic [2:0] LOAD_1024_CYC = 3'h4;
  localparam logic [2:0] CNT_ONE = 3'h1;
  localparam logic [2:0] CNT_ZERO = 3'h0;
  // Strobe domain counts
  localparam logic [2:0] DUMMY_STROBES = 3'h4;
  // Define needs two strobe edges to clear through its synchroniser, so
  // only the rest of the dummy strobes are counted
  localparam logic [2:0] SYNC_STAGES = 3'h2;
  localparam logic [2:0] DUMMY_COUNTED = DUMMY_STROBES - SYNC_STAGES;
  localparam logic [ADDR_W-1:0] ADDR_ZERO = 10'h000;
  localparam logic [ADDR_W-1:0] ADDR_ONE = 10'h001;
  localparam logic [DATA_W-1:0] DATA_ZERO = 32'h0000_0000;

  // Owner of the shared RAM in a given cycle
  typedef enum logic [1:0] {
    OP_COMP = 2'h0,
    OP_IN = 2'h1,
    OP_OUT = 2'h3
  } fosc_op_t;

  // Output sequencer, Gray coded along the path
  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_SEEN = 3'h1,
    ST_SM1 = 3'h3,
    ST_ADDR = 3'h2,
    ST_LATCH = 3'h6,
    ST_OUT = 3'h7
  } fosc_state_t;
endpackage : fosc_pkg

`default_nettype wire

// File: hw/fosc_top.sv
// FFT output strobe control: RAM schedule, output buffer, strobe domain.
// Assumes done, mode and data inputs come from logic on sys_clk_i and
// that the output strobe and enable come from the downstream system.
`default_nettype none

module fosc_top
  import fosc_pkg::*;
(
  // System clock domain
  input wire logic sys_clk_i,
  input wire logic arst_n_i,
  input wire logic clk_en_i,
  // Transform status from the core
  input wire logic done_i,
  input wire logic compute_busy_i,
  input wire logic size_1024_i,
  input wire logic multi_dev_i,
  input wire logic [DATA_W-1:0] res_data_i,
  // Pins from the downstream system
  input wire logic config_define_i,
  input wire logic output_strobe_i,
  input wire logic output_enable_in_i,
  // RAM schedule
  output logic [1:0] ram_op_o,
  // Output pins
  output logic data_available_o,
  output logic [DATA_W-1:0] dout_o,
  output logic dout_oe_o,
  output logic [ADDR_W-1:0] out_addr_o
);

  // System domain state
  logic [3:0] phase;
  logic done_pend;
  logic buf_loaded;
  logic [DATA_W-1:0] out_buf;
  logic [2:0] cnt_1024;
  logic ack_s1, ack_s2, ack_q;
  logic def_s1, def_s2;
  logic den_s1, den_s2;
  logic [1:0] next_op;
  logic load_now;
  // Strobe domain state
  logic flag_q1, flag_q2;
  logic defq1, defq2;
  logic [2:0] init_cnt;
  fosc_state_t st;
  logic ack;
  logic init_done;

  // ---------------- System clock domain ----------------

  // Repeating schedule counter
  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      phase <= SLOT_FIRST;
    end else if (clk_en_i) begin
      if (phase == SLOT_LAST) begin
        phase <= SLOT_FIRST;
      end else begin
        phase <= phase + PHASE_ONE;
      end
    end
  end

  // Who owns the RAM next; 1024 mode gives it to one job at a time
  always_comb begin
    if (size_1024_i) begin
      if (cnt_1024 != CNT_ZERO) begin
        next_op = OP_OUT;
      end else if (compute_busy_i) begin
        next_op = OP_COMP;
      end else begin
        next_op = OP_IN;
      end
    end else if (phase == SLOT_IN_A || phase == SLOT_IN_B) begin
      next_op = OP_IN;
    end else if (phase == SLOT_OUT_A || phase == SLOT_OUT_B) begin
      next_op = OP_OUT;
    end else begin
      next_op = OP_COMP;
    end
  end

  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      ram_op_o <= OP_COMP;
    end else if (clk_en_i) begin
      ram_op_o <= next_op;
    end
  end

  // Pin and handshake synchronisers into the system domain
  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      ack_s1 <= 1'b0;
      ack_s2 <= 1'b0;
      ack_q <= 1'b0;
      def_s1 <= 1'b0;
      def_s2 <= 1'b0;
      den_s1 <= 1'b0;
      den_s2 <= 1'b0;
    end else if (clk_en_i) begin
      ack_s1 <= ack;
      ack_s2 <= ack_s1;
      ack_q <= ack_s2;
      def_s1 <= config_define_i;
      def_s2 <= def_s1;
      den_s1 <= output_enable_in_i;
      den_s2 <= den_s1;
    end
  end

  // Load only when the last handshake has fully closed
  assign load_now = done_pend && !buf_loaded && !ack_s2 &&
    (size_1024_i ? (cnt_1024 == CNT_ONE) :
     (phase == SLOT_OUT_A || phase == SLOT_OUT_B));

  // Completion tracking and 1024-mode handover countdown
  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      done_pend <= 1'b0;
      cnt_1024 <= CNT_ZERO;
    end else if (clk_en_i) begin
      if (done_i) begin
        done_pend <= 1'b1;
      end else if (load_now) begin
        done_pend <= 1'b0;
      end
      if (done_i && size_1024_i) begin
        cnt_1024 <= LOAD_1024_CYC;
      end else if (cnt_1024 != CNT_ZERO) begin
        cnt_1024 <= cnt_1024 - CNT_ONE;
      end
    end
  end

  // Output buffer and its loaded flag; data stays put while flag is up
  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      buf_loaded <= 1'b0;
      out_buf <= DATA_ZERO;
    end else if (clk_en_i) begin
      if (load_now) begin
        buf_loaded <= 1'b1;
        out_buf <= res_data_i;
      end else if (ack_s2) begin
        buf_loaded <= 1'b0;
      end
    end
  end

  // Data available: early at completion when single-device with enable off, or when the first word is out
  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      data_available_o <= 1'b0;
    end else if (clk_en_i) begin
      if (done_i && !multi_dev_i && !den_s2) begin
        data_available_o <= 1'b1;
      end else if (ack_s2 && !ack_q) begin
        data_available_o <= 1'b1;
      end else if (def_s2 || done_i) begin
        data_available_o <= 1'b0;
      end
    end
  end

  // ---------------- Output strobe domain ----------------

  // Two-stage crossing of buffer-loaded flag and configuration define
  always_ff @(posedge output_strobe_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      flag_q1 <= 1'b0;
      flag_q2 <= 1'b0;
      defq1 <= 1'b0;
      defq2 <= 1'b0;
    end else begin
      flag_q1 <= buf_loaded;
      flag_q2 <= flag_q1;
      defq1 <= config_define_i;
      defq2 <= defq1;
    end
  end

  // Dummy strobes after define drops; enable not needed
  always_ff @(posedge output_strobe_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      init_cnt <= CNT_ZERO;
    end else if (defq2) begin
      init_cnt <= CNT_ZERO;
    end else if (init_cnt != DUMMY_COUNTED) begin
      init_cnt <= init_cnt + CNT_ONE;
    end
  end
  assign init_done = (init_cnt == DUMMY_COUNTED);

  // Output sequencer; strobes may arrive at full system rate in any mode
  always_ff @(posedge output_strobe_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      st <= ST_IDLE;
    end else if (defq2) begin
      st <= ST_IDLE;
    end else begin
      unique case (st)
        ST_IDLE: begin
          if (flag_q2 && init_done) begin
            st <= ST_SEEN;
          end
        end
        ST_SEEN: begin
          if (output_enable_in_i) begin
            st <= ST_SM1;
          end
        end
        ST_SM1: begin
          if (output_enable_in_i) begin
            st <= ST_ADDR;
          end
        end
        ST_ADDR: begin
          if (output_enable_in_i) begin
            st <= ST_LATCH;
          end
        end
        ST_LATCH: begin
          if (output_enable_in_i) begin
            st <= ST_OUT;
          end
        end
        ST_OUT: begin
          if (!flag_q2) begin
            st <= ST_IDLE;
          end
        end
        default: begin
          st <= ST_IDLE;
        end
      endcase
    end
  end

  // Address generator counts on the second, third and fourth enabled edges only
  always_ff @(posedge output_strobe_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      out_addr_o <= ADDR_ZERO;
    end else if (defq2 || !init_done) begin
      out_addr_o <= ADDR_ZERO;
    end else if (output_enable_in_i &&
                 (st == ST_SM1 || st == ST_ADDR || st == ST_LATCH)) begin
      out_addr_o <= out_addr_o + ADDR_ONE;
    end
  end

  // Final data latch and pad drive; drive held until next define, data until the next latch
  always_ff @(posedge output_strobe_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      dout_o <= DATA_ZERO;
      dout_oe_o <= 1'b0;
    end else if (defq2) begin
      dout_oe_o <= 1'b0;
    end else if (st == ST_LATCH && output_enable_in_i) begin
      dout_o <= out_buf;
      dout_oe_o <= 1'b1;
    end
  end

  // Handshake back: high while the word is out and the flag still up
  always_ff @(posedge output_strobe_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      ack <= 1'b0;
    end else begin
      ack <= (st == ST_OUT) && flag_q2;
    end
  end

  // ---------------- Checks ----------------

  property p_sched_wrap;
    @(posedge sys_clk_i) disable iff (!arst_n_i)
    (clk_en_i && phase == SLOT_LAST) |=> (phase == SLOT_FIRST);
  endproperty
  a_sched_wrap: assert property (p_sched_wrap)
    else $error("schedule did not wrap after last slot");

  property p_in_slot;
    @(posedge sys_clk_i) disable iff (!arst_n_i)
    (clk_en_i && !size_1024_i && phase == SLOT_IN_B)
      |=> (ram_op_o == OP_IN);
  endproperty
  a_in_slot: assert property (p_in_slot)
    else $error("input slot not given to input");

  property p_out_slot;
    @(posedge sys_clk_i) disable iff (!arst_n_i)
    (clk_en_i && !size_1024_i && phase == SLOT_OUT_A)
      |=> (ram_op_o == OP_OUT);
  endproperty
  a_out_slot: assert property (p_out_slot)
    else $error("output slot not given to output");

  property p_comp_slot;
    @(posedge sys_clk_i) disable iff (!arst_n_i)
    (clk_en_i && !size_1024_i && phase == PHASE_ONE)
      |=> (ram_op_o == OP_COMP);
  endproperty
  a_comp_slot: assert property (p_comp_slot)
    else $error("compute slot lost");

  property p_dav_early;
    @(posedge sys_clk_i) disable iff (!arst_n_i)
    (clk_en_i && done_i && !multi_dev_i && !den_s2)
      |=> data_available_o;
  endproperty
  a_dav_early: assert property (p_dav_early)
    else $error("data available missing at completion");

  property p_dav_held;
    @(posedge sys_clk_i) disable iff (!arst_n_i)
    (clk_en_i && done_i && multi_dev_i && !(ack_s2 && !ack_q))
      |=> !data_available_o;
  endproperty
  a_dav_held: assert property (p_dav_held)
    else $error("data available raised in multi-device mode");

  sequence s_done_small;
    !size_1024_i && !buf_loaded && !ack_s2 && $rose(done_pend);
  endsequence
  property p_load_worst;
    @(posedge sys_clk_i) disable iff (!arst_n_i || !clk_en_i)
    s_done_small |-> ##[1:7] buf_loaded;
  endproperty
  a_load_worst: assert property (p_load_worst)
    else $error("output buffer not loaded in time");

  sequence s_done_big;
    size_1024_i && !buf_loaded && !ack_s2 && $rose(done_pend);
  endsequence
  property p_load_1024;
    @(posedge sys_clk_i) disable iff (!arst_n_i || !clk_en_i)
    s_done_big |-> !buf_loaded [*4] ##1 buf_loaded;
  endproperty
  a_load_1024: assert property (p_load_1024)
    else $error("1024-point load not exactly four cycles");

  property p_seen;
    @(posedge output_strobe_i) disable iff (!arst_n_i)
    (st == ST_IDLE && flag_q2 && init_done && !defq2) |=> (st == ST_SEEN);
  endproperty
  a_seen: assert property (p_seen)
    else $error("loaded flag not taken on strobe");

  property p_wait_en;
    @(posedge output_strobe_i) disable iff (!arst_n_i)
    (st == ST_ADDR && !output_enable_in_i && !defq2) |=> (st == ST_ADDR);
  endproperty
  a_wait_en: assert property (p_wait_en)
    else $error("sequencer stepped without enable");

  property p_fourth;
    @(posedge output_strobe_i) disable iff (!arst_n_i)
    (st == ST_LATCH && output_enable_in_i && !defq2)
      |=> (dout_oe_o && st == ST_OUT && dout_o == $past(out_buf));
  endproperty
  a_fourth: assert property (p_fourth)
    else $error("first word not presented on fourth enabled edge");

  property p_dummy;
    @(posedge output_strobe_i) disable iff (!arst_n_i)
    defq2 |=> (init_cnt == CNT_ZERO && out_addr_o == ADDR_ZERO);
  endproperty
  a_dummy: assert property (p_dummy)
    else $error("address counters not initialised by define");

endmodule : fosc_top

`default_nettype wire

// File: tb/fosc_strobe_model.sv
// Downstream controller model: output strobe and output enable.
// Assumes the bench calls its tasks; strobe stands low between bursts.
`default_nettype none

module fosc_strobe_model (
  // Pins toward the block
  output var logic strobe_o,
  output var logic enable_o
);
  timeunit 1ns;
  timeprecision 1ps;

  // Idle: strobe parked low, enable off
  initial begin
    strobe_o = 1'b0;
    enable_o = 1'b0;
  end

  // Burst of 32 ns high strobes at a 64 ns period; enable set while strobe is low
  task automatic pulses(input int n, input logic en);
    enable_o = en;
    for (int i = 0; i < n; i++) begin
      #32;
      strobe_o = 1'b1;
      #32;
      strobe_o = 1'b0;
    end
  endtask : pulses

  // Level change of enable with no strobe
  task automatic hold_en(input logic en);
    enable_o = en;
  endtask : hold_en
endmodule : fosc_strobe_model

`default_nettype wire

// File: tb/tb_top.sv
// Self-checking bench for the FFT output strobe control block.
// Assumes a 20 MHz system clock and the strobe model as far side.
`default_nettype none

module tb_top;
  import fosc_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;

  localparam logic [DATA_W-1:0] PAT = 32'hA5C3_0F96;
  logic sys_clk, arst_n, clk_en, done, busy, sz1024, multi, cfg_def;
  logic strobe, enable, data_available, oe;
  logic [1:0] ram_op;
  logic [DATA_W-1:0] dout;
  logic [ADDR_W-1:0] addr;
  int n_errors = 0;
  int checks_done = 0;

  fosc_strobe_model mdl_u (.strobe_o(strobe), .enable_o(enable));

  fosc_top dut_u (
    .sys_clk_i(sys_clk), .arst_n_i(arst_n), .clk_en_i(clk_en),
    .done_i(done), .compute_busy_i(busy), .size_1024_i(sz1024),
    .multi_dev_i(multi), .res_data_i(PAT), .config_define_i(cfg_def),
    .output_strobe_i(strobe), .output_enable_in_i(enable),
    .ram_op_o(ram_op), .data_available_o(data_available), .dout_o(dout),
    .dout_oe_o(oe), .out_addr_o(addr)
  );

  // 50 ns system clock
  initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end

  task automatic check_val(input logic [31:0] got, input logic [31:0] exp,
                           input string msg);
    checks_done++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED at %0t: %s got %h exp %h", $time, msg, got, exp);
    end
  endtask : check_val

  task automatic finish_test();
    $display("errors %0d checks %0d", n_errors, checks_done);
    if (n_errors == 0 && checks_done > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : finish_test

  task automatic cycles(input int n);
    repeat (n) @(negedge sys_clk);
  endtask : cycles

  // One-cycle completion pulse, taken on the next rising edge
  task automatic pulse_done();
    @(negedge sys_clk) done = 1'b1;
    @(negedge sys_clk) done = 1'b0;
  endtask : pulse_done

  // Mode change: define pulse seen by both domains, then dummy strobes
  task automatic def_init();
    @(negedge sys_clk) cfg_def = 1'b1;
    mdl_u.pulses(2, 1'b0);
    cycles(3);
    cfg_def = 1'b0;
    cycles(3);
    mdl_u.pulses(4, 1'b0);
    cycles(4);
    check_val(data_available, 1'b0, "dav after define");
    check_val(oe, 1'b0, "pads after define");
    check_val(addr, ADDR_ZERO, "address init");
  endtask : def_init

  // Count owners over one schedule
  task automatic count_ops(output int n_in, output int n_out,
                           output int n_comp);
    n_in = 0;
    n_out = 0;
    n_comp = 0;
    repeat (12) begin
      @(negedge sys_clk);
      if (ram_op === OP_IN) n_in++;
      if (ram_op === OP_OUT) n_out++;
      if (ram_op === OP_COMP) n_comp++;
    end
  endtask : count_ops

  task automatic t_sched();
    int ni, no, nc;
    count_ops(ni, no, nc);
    check_val(ni, 2, "input slots");
    check_val(no, 2, "output slots");
    check_val(nc, 8, "compute slots");
    check_val(ni + no + nc, 12, "schedule length");
  endtask : t_sched

  task automatic t_dump();
    def_init();
    pulse_done();
    cycles(1);
    check_val(data_available, 1'b1, "dav at completion");
    cycles(6);
    mdl_u.pulses(3, 1'b0);
    check_val(oe, 1'b0, "pads after carry edges");
    mdl_u.pulses(3, 1'b1);
    check_val(oe, 1'b0, "pads after three enabled");
    check_val(addr, ADDR_ONE + ADDR_ONE, "address counting");
    mdl_u.pulses(1, 1'b1);
    check_val(oe, 1'b1, "pads driven on fourth");
    check_val(dout, PAT, "first result");
  endtask : t_dump

  task automatic t_quiet();
    bit seen;
    def_init();
    mdl_u.hold_en(1'b1);
    cycles(4);
    pulse_done();
    cycles(3);
    check_val(data_available, 1'b0, "dav with enable on");
    mdl_u.hold_en(1'b0);
    multi = 1'b1;
    cycles(4);
    pulse_done();
    cycles(3);
    check_val(data_available, 1'b0, "dav in multi mode");
    multi = 1'b0;
    cycles(6);
    mdl_u.pulses(8, 1'b1);
    seen = 1'b0;
    for (int i = 0; i < 20 && !seen; i++) begin
      cycles(1);
      seen = (data_available === 1'b1);
    end
    check_val(seen, 1'b1, "dav raised by output");
    check_val(oe, 1'b1, "pads with dav");
    // Frozen system domain ignores completion
    def_init();
    clk_en = 1'b0;
    pulse_done();
    cycles(3);
    check_val(data_available, 1'b0, "dav while frozen");
    clk_en = 1'b1;
  endtask : t_quiet

  task automatic t_1024();
    int ni, no, nc, k;
    def_init();
    sz1024 = 1'b1;
    busy = 1'b1;
    count_ops(ni, no, nc);
    check_val(nc, 12, "transform owns RAM");
    busy = 1'b0;
    count_ops(ni, no, nc);
    check_val(ni, 12, "all cycles input");
    busy = 1'b1;
    pulse_done();
    busy = 1'b0;
    k = 0;
    check_val(ram_op, OP_COMP, "transform owns RAM at done");
    cycles(1);
    check_val(ram_op, OP_OUT, "handover starts");
    cycles(3);
    check_val(ram_op, OP_OUT, "handover fourth cycle");
    cycles(1);
    check_val(ram_op, OP_IN, "handover over after four");
    check_val(data_available, 1'b1, "dav in 1024 mode");
    cycles(4);
    mdl_u.pulses(7, 1'b1);
    check_val(oe, 1'b1, "pads in 1024 mode");
    check_val(dout, PAT, "result in 1024 mode");
    sz1024 = 1'b0;
  endtask : t_1024

  // Main sequence
  initial begin
    arst_n = 1'b0;
    clk_en = 1'b1;
    done = 1'b0;
    busy = 1'b0;
    sz1024 = 1'b0;
    multi = 1'b0;
    cfg_def = 1'b0;
    repeat (8) @(posedge sys_clk);
    @(negedge sys_clk) arst_n = 1'b1;
    check_val(data_available, 1'b0, "dav reset");
    check_val(oe, 1'b0, "pads reset");
    check_val(dout, DATA_ZERO, "data reset");
    t_sched();
    t_dump();
    t_quiet();
    t_1024();
    finish_test();
  end

  // Hang guard, well beyond the two hundred or so cycles used
  initial begin
    #500us;
    n_errors++;
    finish_test();
  end
endmodule : tb_top

`default_nettype wire
